//--- core/link_diag_regs.svh
`ifndef LINK_DIAG_REGS_SVH
`define LINK_DIAG_REGS_SVH

// ----------------------------------------------------------------------------
// Register indexes; the byte address on the bus is four times the index.
// ----------------------------------------------------------------------------
`define IDX_LOOPBACK_CTRL      8'h12
`define IDX_RESET_DEBUG_CTRL   8'h13
`define IDX_ALIGN_STATUS       8'h20
`define IDX_BLOCK_LOCK         8'h21
`define IDX_MFRAME_LOCK        8'h22
`define IDX_CRC_CNT_A          8'h23
`define IDX_CRC_CNT_B          8'h24
`define IDX_CRC_CNT_C          8'h25
`define IDX_CRC_CNT_D          8'h26
`define IDX_RX_ALIGN_STICKY    8'h80
`define IDX_TX_ALIGN_STICKY    8'h81
`define IDX_CRC_INJECT_CTRL    8'h82
`define IDX_IRQ_STATUS         8'h90
`define IDX_IRQ_ENABLE         8'h91
`define IDX_IRQ_CLEAR          8'h92

// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define BIT_RST_LOCK_REF       8
`define BIT_RST_TX_CLEAR       7
`define BIT_RST_RX_CLEAR       6
`define BIT_ALIGN_TX           0
`define BIT_ALIGN_RX           11
`define BIT_ALIGN_FEC_AM       12
`define BIT_STICKY_LOSS        0
`define BIT_IRQ_RX_LOSS        0
`define BIT_IRQ_TX_LOSS        1
`define BIT_IRQ_CRC_ERR        2

// ----------------------------------------------------------------------------
// Reset values and limits.
// ----------------------------------------------------------------------------
`define RST_CTRL_ZERO          32'h0000_0000
`define CRC_CNT_MAX            4'hF
`define RESET_DEBUG_MASK       32'h0000_01C0
`define IRQ_BITS               3

`endif

//--- core/link_diag_pkg.sv
package link_diag_pkg;

    typedef logic [3:0] crc_cnt_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK  = 2'b01
    } bus_state_t;

endpackage

//--- core/link_diag_status_regs.sv
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/10ps
`include "link_diag_regs.svh"

module link_diag_status_regs #(
    parameter int NUM_LANES = 24
) (
    input  wire logic                   i_clk_sys,
    input  wire logic                   i_srst,
    input  wire logic                   i_wb_cyc,
    input  wire logic                   i_wb_stb,
    input  wire logic                   i_wb_we,
    input  wire logic [9:0]             i_wb_adr,
    input  wire logic [3:0]             i_wb_sel,
    input  wire logic [31:0]            i_wb_dat,
    output logic      [31:0]            o_wb_dat,
    output logic                        o_wb_ack,
    input  wire logic                   i_tx_lanes_aligned,
    input  wire logic                   i_rx_lanes_aligned,
    input  wire logic                   i_fec_am_sync,
    input  wire logic [NUM_LANES-1:0]   i_block_lock,
    input  wire logic [NUM_LANES-1:0]   i_mframe_lock,
    input  wire logic [NUM_LANES-1:0]   i_crc_fail,
    output logic      [NUM_LANES-1:0]   o_loopback_en,
    output logic      [NUM_LANES-1:0]   o_crc_inject,
    output logic                        o_lock_to_ref,
    output logic                        o_tx_clear,
    output logic                        o_rx_clear,
    output logic                        o_irq
);
    import link_diag_pkg::*;

    // ------------------------------------------------------------------------
    // Bus slave.
    // ------------------------------------------------------------------------
    bus_state_t             bus_q;
    logic                   req;
    logic                   wr;
    logic [7:0]             idx;
    logic [31:0]            wmask;
    logic [31:0]            rdata;

    // Narrower-than-32 lane vectors sit in the low bits of each word.
    function automatic logic [31:0] widen(input logic [NUM_LANES-1:0] v);
        logic [31:0] r;
        r = 32'h0000_0000;
        r[NUM_LANES-1:0] = v;
        return r;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [31:0] m);
        return (old_v & ~m) | (new_v & m);
    endfunction

    assign req   = i_wb_cyc && i_wb_stb && (bus_q == BUS_IDLE);
    assign wr    = req && i_wb_we;
    assign idx   = i_wb_adr[9:2];
    assign wmask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};

    // Every register write is decoded through this one place.
    function automatic logic wr_hit(input logic [7:0] x);
        return wr && (idx == x);
    endfunction

    // One cycle of latency for every access keeps the master's wait short and fixed.
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            bus_q    <= BUS_IDLE;
            o_wb_ack <= 1'b0;
        end else begin
            case (bus_q)
                BUS_IDLE: begin
                    bus_q    <= req ? BUS_ACK : BUS_IDLE;
                    o_wb_ack <= req;
                end
                BUS_ACK: begin
                    bus_q    <= BUS_IDLE;
                    o_wb_ack <= 1'b0;
                end
                default: begin
                    bus_q    <= BUS_IDLE;
                    o_wb_ack <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Control registers.
    // ------------------------------------------------------------------------
    logic [31:0]            loop_q;
    logic [31:0]            inject_q;
    logic [31:0]            rstdbg_q;
    logic [31:0]            irq_en_q;

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            loop_q <= `RST_CTRL_ZERO;
        end else if (wr_hit(`IDX_LOOPBACK_CTRL)) begin
            loop_q <= merge(loop_q, i_wb_dat, wmask) & widen('1);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            inject_q <= `RST_CTRL_ZERO;
        end else if (wr_hit(`IDX_CRC_INJECT_CTRL)) begin
            // The bit is a plain level; the data path keeps it for a metaframe.
            inject_q <= merge(inject_q, i_wb_dat, wmask) & widen('1);
        end
    end

    // Reset value zero leaves automatic reset control in charge.
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            rstdbg_q <= `RST_CTRL_ZERO;
        end else if (wr_hit(`IDX_RESET_DEBUG_CTRL)) begin
            rstdbg_q <= merge(rstdbg_q, i_wb_dat, wmask) & `RESET_DEBUG_MASK;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            irq_en_q <= `RST_CTRL_ZERO;
        end else if (wr_hit(`IDX_IRQ_ENABLE)) begin
            irq_en_q <= merge(irq_en_q, i_wb_dat, wmask);
        end
    end

    // ------------------------------------------------------------------------
    // Output registers.
    // ------------------------------------------------------------------------
    // Registering costs one cycle after a write but gives the data path clean levels.
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_loopback_en <= '0;
        end else begin
            o_loopback_en <= loop_q[NUM_LANES-1:0];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_crc_inject <= '0;
        end else begin
            o_crc_inject <= inject_q[NUM_LANES-1:0];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_lock_to_ref <= 1'b0;
        end else begin
            o_lock_to_ref <= rstdbg_q[`BIT_RST_LOCK_REF];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_tx_clear <= 1'b0;
        end else begin
            o_tx_clear <= rstdbg_q[`BIT_RST_TX_CLEAR];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_rx_clear <= 1'b0;
        end else begin
            o_rx_clear <= rstdbg_q[`BIT_RST_RX_CLEAR];
        end
    end

    // ------------------------------------------------------------------------
    // Status capture.
    // ------------------------------------------------------------------------
    logic                   tx_clr;
    logic                   rx_clr;
    logic                   tx_al_q;
    logic                   rx_al_q;
    logic                   tx_loss_q;
    logic                   rx_loss_q;
    logic                   tx_loss_ev;
    logic                   rx_loss_ev;
    crc_cnt_t               crc_cnt_q [NUM_LANES];
    logic                   crc_ev;

    // A loss event is a one-cycle fall of an aligned level.
    function automatic logic level_fell(input logic prev, input logic now);
        return prev && !now;
    endfunction

    assign tx_clr     = rstdbg_q[`BIT_RST_TX_CLEAR];
    assign rx_clr     = rstdbg_q[`BIT_RST_RX_CLEAR];
    assign tx_loss_ev = level_fell(tx_al_q, i_tx_lanes_aligned);
    assign rx_loss_ev = level_fell(rx_al_q, i_rx_lanes_aligned);
    assign crc_ev     = |i_crc_fail;

    // Reset to not aligned, so a pin that is low out of reset raises no false loss event.
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            tx_al_q <= 1'b0;
        end else begin
            tx_al_q <= i_tx_lanes_aligned;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            rx_al_q <= 1'b0;
        end else begin
            rx_al_q <= i_rx_lanes_aligned;
        end
    end

    // ------------------------------------------------------------------------
    // Alignment loss flags.
    // ------------------------------------------------------------------------
    // The clear is a level held by software, so it dominates while held.
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            rx_loss_q <= 1'b0;
        end else if (rx_clr) begin
            rx_loss_q <= 1'b0;
        end else if (rx_loss_ev) begin
            rx_loss_q <= 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            tx_loss_q <= 1'b0;
        end else if (tx_clr) begin
            tx_loss_q <= 1'b0;
        end else if (tx_loss_ev) begin
            tx_loss_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // CRC error counters.
    // ------------------------------------------------------------------------
    // A count holds at its top value; wrapping would make a burst look like a few errors.
    function automatic crc_cnt_t sat_inc(input crc_cnt_t c);
        if (c == `CRC_CNT_MAX) begin
            return c;
        end
        return c + 4'h1;
    endfunction

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            for (int l = 0; l < NUM_LANES; l++) begin
                crc_cnt_q[l] <= 4'h0;
            end
        end else begin
            for (int l = 0; l < NUM_LANES; l++) begin
                if (rx_clr) begin
                    crc_cnt_q[l] <= 4'h0;
                end else if (i_crc_fail[l]) begin
                    crc_cnt_q[l] <= sat_inc(crc_cnt_q[l]);
                end
            end
        end
    end

    // Eight 4-bit counters per word, lane 8*g in the low nibble.
    function automatic logic [31:0] crc_word(input int g);
        logic [31:0] r;
        r = 32'h0000_0000;
        for (int k = 0; k < 8; k++) begin
            if (g * 8 + k < NUM_LANES) begin
                r[k*4 +: 4] = crc_cnt_q[g*8 + k];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------------------
    // Interrupts.
    // ------------------------------------------------------------------------
    logic [`IRQ_BITS-1:0]   irq_st_q;
    logic [`IRQ_BITS-1:0]   irq_set;
    logic [`IRQ_BITS-1:0]   irq_clr;

    assign irq_set = {crc_ev, tx_loss_ev, rx_loss_ev};
    assign irq_clr = wr_hit(`IDX_IRQ_CLEAR) ? (i_wb_dat[`IRQ_BITS-1:0] & wmask[`IRQ_BITS-1:0])
                                                    : '0;

    // A new event in the clearing cycle wins over the clear.
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            irq_st_q <= '0;
        end else begin
            irq_st_q <= (irq_st_q & ~irq_clr) | irq_set;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(irq_st_q & irq_en_q[`IRQ_BITS-1:0]);
        end
    end

    // ------------------------------------------------------------------------
    // Read decode.
    // ------------------------------------------------------------------------
    always_comb begin
        rdata = 32'h0000_0000;
        if (idx == `IDX_LOOPBACK_CTRL) begin
            rdata = loop_q;
        end else if (idx == `IDX_RESET_DEBUG_CTRL) begin
            rdata = rstdbg_q;
        end else if (idx == `IDX_ALIGN_STATUS) begin
            rdata[`BIT_ALIGN_TX]     = i_tx_lanes_aligned;
            rdata[`BIT_ALIGN_RX]     = i_rx_lanes_aligned;
            rdata[`BIT_ALIGN_FEC_AM] = i_fec_am_sync;
        end else if (idx == `IDX_BLOCK_LOCK) begin
            rdata = widen(i_block_lock);
        end else if (idx == `IDX_MFRAME_LOCK) begin
            rdata = widen(i_mframe_lock);
        end else if (idx == `IDX_CRC_CNT_A) begin
            rdata = crc_word(0);
        end else if (idx == `IDX_CRC_CNT_B) begin
            rdata = crc_word(1);
        end else if (idx == `IDX_CRC_CNT_C) begin
            rdata = crc_word(2);
        end else if (idx == `IDX_CRC_CNT_D) begin
            rdata = crc_word(3);
        end else if (idx == `IDX_RX_ALIGN_STICKY) begin
            rdata[`BIT_STICKY_LOSS] = rx_loss_q;
        end else if (idx == `IDX_TX_ALIGN_STICKY) begin
            rdata[`BIT_STICKY_LOSS] = tx_loss_q;
        end else if (idx == `IDX_CRC_INJECT_CTRL) begin
            rdata = inject_q;
        end else if (idx == `IDX_IRQ_STATUS) begin
            rdata[`IRQ_BITS-1:0] = irq_st_q;
        end else if (idx == `IDX_IRQ_ENABLE) begin
            rdata = irq_en_q;
        end
    end

    // ------------------------------------------------------------------------
    // Read data register.
    // ------------------------------------------------------------------------
    // Read data stays until the next read, so a slow master can still pick it up.
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_wb_dat <= 32'h0000_0000;
        end else if (req && !i_wb_we) begin
            o_wb_dat <= rdata;
        end
    end

endmodule

//--- sim/link_diag_checker.sv
`timescale 1ns/10ps
module link_diag_checker #(
    parameter int NUM_LANES = 24
) (
    input wire logic                 i_clk_sys,
    input wire logic                 i_srst,
    input wire logic                 i_wb_cyc,
    input wire logic                 i_wb_stb,
    input wire logic                 i_wb_we,
    input wire logic [9:0]           i_wb_adr,
    input wire logic [31:0]          i_wb_dat,
    input wire logic [31:0]          o_wb_dat,
    input wire logic                 o_wb_ack,
    input wire logic                 i_tx_lanes_aligned,
    input wire logic                 i_rx_lanes_aligned,
    input wire logic [NUM_LANES-1:0] o_loopback_en,
    input wire logic                 o_lock_to_ref,
    input wire logic                 o_tx_clear,
    input wire logic                 o_rx_clear
);
    localparam logic [31:0] LM = 32'((64'h1 << NUM_LANES) - 1);
    // Controls follow a write two edges after it is taken: register first, then output flop.
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_srst);
    sequence s_req(logic w, logic [7:0] x);
        i_wb_cyc && i_wb_stb && !o_wb_ack && i_wb_we == w && i_wb_adr[9:2] == x;
    endsequence
    property p_ack_lat;
        i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack;
    endproperty
    property p_ack_one;
        o_wb_ack |=> !o_wb_ack;
    endproperty
    property p_ack_cause;
        $rose(o_wb_ack) |-> $past(i_wb_cyc && i_wb_stb);
    endproperty
    property p_ctl(logic [7:0] x, logic [31:0] m, logic [31:0] y);
        logic [31:0] d;
        (s_req(1'b1, x), d = i_wb_dat) |-> ##2 (y == (d & m));
    endproperty
    property p_rd(logic [7:0] x, logic [31:0] m, logic [31:0] v);
        s_req(1'b0, x) |=> (o_wb_dat & m) == $past(v);
    endproperty
    a_ack_lat: assert property (p_ack_lat) else $error("no ack");
    a_ack_one: assert property (p_ack_one) else $error("ack too long");
    a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
    a_loop: assert property (p_ctl(8'h12, LM, 32'(o_loopback_en))) else $error("loopback");
    a_lock: assert property (p_ctl(8'h13, 32'h0000_0100, 32'(o_lock_to_ref) << 8)) else $error("lock");
    a_txc: assert property (p_ctl(8'h13, 32'h0000_0080, 32'(o_tx_clear) << 7)) else $error("tx clear");
    a_rxc: assert property (p_ctl(8'h13, 32'h0000_0040, 32'(o_rx_clear) << 6)) else $error("rx clear");
    a_align: assert property (p_rd(8'h20, 32'h0000_0801,
        {20'h0_0000, i_rx_lanes_aligned, 10'h000, i_tx_lanes_aligned})) else $error("align");
    a_unmap: assert property (p_rd(8'h40, 32'hFFFF_FFFF, 32'h0000_0000)) else $error("unmapped");
endmodule

//--- sim/link_diag_status_regs_tb_top.sv
`timescale 1ns/10ps
module link_diag_status_regs_tb_top;
    import link_diag_pkg::*;
    localparam int         NL = 24;
    localparam logic [7:0] RZ [13] = '{8'h12, 8'h13, 8'h23, 8'h24, 8'h25, 8'h26, 8'h40, 8'h80, 8'h81, 8'h82,
                                       8'h90, 8'h91, 8'h92};
    logic          i_clk_sys = 1'b0, i_srst = 1'b1, i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
    logic          i_tx_lanes_aligned = 1'b1, i_rx_lanes_aligned = 1'b1, i_fec_am_sync = 1'b0;
    logic          o_wb_ack, o_lock_to_ref, o_tx_clear, o_rx_clear, o_irq;
    logic [9:0]    i_wb_adr = 10'h000;
    logic [3:0]    i_wb_sel = 4'h0, sl;
    logic [31:0]   i_wb_dat = 32'h0000_0000, o_wb_dat, rd, wd;
    logic [NL-1:0] i_block_lock = '0, i_mframe_lock = '0, i_crc_fail = '0, o_loopback_en, o_crc_inject;
    crc_cnt_t      cnt [32] = '{default: 4'h0};
    logic [31:0]   sh [2] = '{default: 32'h0000_0000};
    int            miscompares = 0, checks_done = 0;
    always #5 i_clk_sys = ~i_clk_sys;
    link_diag_status_regs #(.NUM_LANES(NL)) u_dut (
        .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
        .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
        .i_tx_lanes_aligned(i_tx_lanes_aligned), .i_rx_lanes_aligned(i_rx_lanes_aligned),
        .i_fec_am_sync(i_fec_am_sync), .i_block_lock(i_block_lock), .i_mframe_lock(i_mframe_lock),
        .i_crc_fail(i_crc_fail), .o_loopback_en(o_loopback_en), .o_crc_inject(o_crc_inject),
        .o_lock_to_ref(o_lock_to_ref), .o_tx_clear(o_tx_clear), .o_rx_clear(o_rx_clear), .o_irq(o_irq)
    );
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic tally_and_finish;
        if (miscompares == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] x, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        {i_wb_cyc, i_wb_stb, i_wb_we} <= {2'b11, w};
        i_wb_adr <= {x, 2'b00};
        i_wb_dat <= d;
        i_wb_sel <= s;
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (o_wb_ack !== 1'b1);
        rd = o_wb_dat;
        chk(32'(n), 32'h0000_0002);
        {i_wb_cyc, i_wb_stb} <= 2'b00;
        i_wb_adr <= ~{x, 2'b00};
        i_wb_dat <= ~d;
        @(posedge i_clk_sys);
    endtask
    task automatic wr(input logic [7:0] x, input logic [31:0] d);
        wb(1'b1, x, d, 4'hF);
    endtask
    task automatic rdc(input logic [7:0] x, input logic [31:0] e);
        wb(1'b0, x, 32'h0000_0000, 4'h0);
        chk(rd, e);
    endtask
    function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n, logic [3:0] s);
        for (int b = 0; b < 4; b++) merge[8*b +: 8] = s[b] ? n[8*b +: 8] : o[8*b +: 8];
    endfunction
    function automatic logic [31:0] pack(int g);
        for (int k = 0; k < 8; k++) pack[4*k +: 4] = cnt[8*g+k];
    endfunction
    initial begin
        void'($urandom(32'h86f8));
        repeat (20) @(posedge i_clk_sys);
        i_srst <= 1'b0;
        @(posedge i_clk_sys);
        foreach (RZ[i]) rdc(RZ[i], 32'h0000_0000);
        chk({o_lock_to_ref, o_tx_clear, o_rx_clear, o_irq, o_loopback_en | o_crc_inject}, 32'h0000_0000);
        for (int i = 0; i < 16; i++) begin
            wd = (i < 2) ? 32'hFFFF_FFFF : (i > 13) ? 32'h0000_0000 : $urandom();
            sl = (i < 4 || i > 13 || !i[0]) ? 4'hF : 4'($urandom());
            wb(1'b1, i[0] ? 8'h82 : 8'h12, wd, sl);
            sh[i[0]] = merge(sh[i[0]], wd, sl) & 32'h00FF_FFFF;
            rdc(i[0] ? 8'h82 : 8'h12, sh[i[0]]);
            chk(32'(i[0] ? o_crc_inject : o_loopback_en), sh[i[0]]);
        end
        wr(8'h13, 32'hFFFF_FFFF);
        rdc(8'h13, 32'h0000_01C0);
        chk({o_lock_to_ref, o_tx_clear, o_rx_clear, 29'h0000_0000}, 32'hE000_0000);
        for (int i = 0; i < 8; i++) begin
            wd = (i == 0) ? 32'hFFFF_FFFF : $urandom();
            {i_tx_lanes_aligned, i_rx_lanes_aligned, i_fec_am_sync} <= wd[2:0];
            i_block_lock <= wd[NL+7:8];
            i_mframe_lock <= ~wd[NL-1:0];
            // Expectations come from wd, since the input updates above land only after this call starts.
            wb(1'b0, 8'h20, 32'h0000_0000, 4'h0);
            chk(rd & 32'h0000_1801, {19'h0_0000, wd[0], wd[1], 10'h000, wd[2]});
            rdc(8'h21, 32'(wd[NL+7:8]));
            rdc(8'h22, {8'h00, ~wd[NL-1:0]});
        end
        {i_tx_lanes_aligned, i_rx_lanes_aligned} <= 2'b11;
        wr(8'h13, 32'h0000_01C0);
        wr(8'h13, 32'h0000_0000);
        for (int c = 0; c < 40; c++) begin
            wd = (c < 18) ? ($urandom() | 32'h0000_0001) : ($urandom() & $urandom());
            i_crc_fail <= wd[NL-1:0];
            for (int l = 0; l < NL; l++) if (wd[l] && cnt[l] != 4'hF) cnt[l]++;
            @(posedge i_clk_sys);
        end
        i_crc_fail <= '0;
        for (int k = 0; k < 3; k++) begin
            wr(8'h13, 32'h0000_0100 >> k);
            wr(8'h13, 32'h0000_0000);
            if (k == 2) cnt = '{default: 4'h0};
            for (int g = 0; g < 4; g++) rdc(8'h23 + 8'(g), pack(g));
        end
        wr(8'h92, 32'h0000_0007);
        wr(8'h91, 32'h0000_0001);
        rdc(8'h91, 32'h0000_0001);
        for (int k = 0; k < 2; k++) begin
            {i_tx_lanes_aligned, i_rx_lanes_aligned} <= k ? 2'b01 : 2'b10;
            @(posedge i_clk_sys);
            {i_tx_lanes_aligned, i_rx_lanes_aligned} <= 2'b11;
            repeat (2) @(posedge i_clk_sys);
            rdc(8'h90, 32'h0000_0001 << k);
            chk(32'(o_irq), 32'(k == 0));
            wr(8'h92, 32'h0000_0007);
            chk(32'(o_irq), 32'h0000_0000);
            for (int j = 0; j < 2; j++) begin
                wr(8'h13, j ? 32'h0000_0040 << k : 32'h0000_0080 >> k);
                wr(8'h13, 32'h0000_0000);
                rdc(8'h80 + 8'(k), 32'(j == 0));
            end
        end
        tally_and_finish;
    end
    initial begin
        repeat (5000) @(posedge i_clk_sys);
        chk(32'h0000_0000, 32'h0000_0001);
        tally_and_finish;
    end
endmodule
bind link_diag_status_regs link_diag_checker #(.NUM_LANES(NUM_LANES)) u_chk (
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
    .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
    .i_tx_lanes_aligned(i_tx_lanes_aligned), .i_rx_lanes_aligned(i_rx_lanes_aligned),
    .o_loopback_en(o_loopback_en), .o_lock_to_ref(o_lock_to_ref), .o_tx_clear(o_tx_clear), .o_rx_clear(o_rx_clear)
);
